// >>> rtl/ofis_cfg.svh
`ifndef OFIS_CFG_SVH
`define OFIS_CFG_SVH
// read sequence operands
`define OFIS_READ_OP0 8'hEE
`define OFIS_READ_OP1 8'h13
`define OFIS_ADDR_OPND 8'h20
`define OFIS_DUMMY_OPND 8'h14
`define OFIS_READ_OPND 8'h10
// identity, erase, program
`define OFIS_ID_OP 8'h9F
`define OFIS_ID_LEN 5'h03
`define OFIS_ERASE_OP0 8'h21
`define OFIS_ERASE_OP1 8'hDE
`define OFIS_ERASE_EXP 5'h0C
`define OFIS_PAGE_SIZE 9'h100
`define OFIS_SR_LEN 5'h01
// other opcodes, values arbitrary
`define OFIS_WREN_OP 8'h06
`define OFIS_SR_OP 8'h05
`define OFIS_RST_ARM_OP 8'h66
`define OFIS_RST_OP 8'h99
`define OFIS_PROG_OP 8'h12
`define OFIS_MODE_RD_OP 8'h71
`define OFIS_MODE_WR_OP 8'h72
// mode register layout
`define OFIS_MODE_ADDR 32'h0000_0000
`define OFIS_IF_MASK 8'h03
`define OFIS_IF_SPI 2'h0
`define OFIS_IF_DTR 2'h2
`define OFIS_PARITY_BIT 3
// status byte layout
`define OFIS_BUSY_BIT 0
`define OFIS_LATCH_BIT 1
// link framing
`define OFIS_ADDR_BYTES 4'h4
`define OFIS_SYNC_LAT 10'h002
`endif

// >>> rtl/ofis_pkg.sv
package ofis_pkg;
    typedef enum logic [11:0] {
        S_IDLE   = 12'h001,
        S_RSTARM = 12'h002,
        S_RST    = 12'h004,
        S_CFGSPI = 12'h008,
        S_IDREAD = 12'h010,
        S_MODERD = 12'h020,
        S_WREN   = 12'h040,
        S_CHKLAT = 12'h080,
        S_MODEWR = 12'h100,
        S_RUN    = 12'h200,
        S_POLL   = 12'h400,
        S_CFGDTR = 12'h800
    } ofis_state_e;
    typedef enum logic [1:0] {
        K_READ  = 2'h0,
        K_ERASE = 2'h1,
        K_PROG  = 2'h2
    } ofis_kind_e;
    typedef enum logic [1:0] {
        L_IDLE = 2'h1,
        L_XFER = 2'h2
    } ofis_link_e;
    typedef struct packed {
        logic [7:0] c0;
        logic [7:0] c1;
        logic [1:0] ncmd;
        logic addr_en;
        logic [31:0] addr;
        logic [7:0] dummy;
        logic [8:0] nwr;
        logic [31:0] wdata;
        logic [4:0] nrd;
    } ofis_job_s;
endpackage

// >>> rtl/ofis_seq.sv
`timescale 1ns/10ps
`include "ofis_cfg.svh"
// Overview of operation
// - read opens with opcodes EE then 13
// - read sends 32-bit address after opcodes
// - read inserts dummy phase of 0x14
// - read data phase length operand 0x10
// - compare identity with expected, flag mismatch
// - identity read: opcode 9F, three bytes
// - first identity byte lands in low byte
// - erase sends 21 then DE, address
// - erase span is two to the setting
// - set write latch before program, erase
// - status reads transfer one byte
// - init steps use ten step kinds
// - mode change then controller reconfigure
// - reset arm directly followed by reset
// - reapply single-line config after reset
module ofis_seq
    import ofis_pkg::*;
#(
    parameter logic [23:0] EXPECTED_ID = 24'h5A1B2C // arbitrary value
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic lclk,
    input wire logic init_start,
    input wire logic op_valid,
    input wire logic [1:0] op_kind,
    input wire logic [31:0] op_addr,
    input wire logic [8:0] op_len,
    input wire logic [31:0] op_wdata,
    input wire logic parity_en,
    output logic busy,
    output logic init_done,
    output logic id_error,
    output logic [23:0] id_value,
    output logic [31:0] rd_data,
    output logic op_done,
    output logic [1:0] ctrl_mode,
    output logic [7:0] volatile_mode_cfg_register,
    output logic flash_cs_n,
    output logic [7:0] sio_out,
    output logic sio_oe_n,
    input wire logic [7:0] sio_in
);
    localparam logic [31:0] ERASE_SPAN = 32'h1 << `OFIS_ERASE_EXP;

    // job descriptor for the current step
    function automatic ofis_job_s job_of(input ofis_state_e st,
            input logic [1:0] kind, input logic [31:0] addr,
            input logic [8:0] len, input logic [31:0] wd,
            input logic [7:0] mode, input logic par);
        ofis_job_s j;
        j = '0;
        j.ncmd = 2'h1;
        case (st)
            S_RSTARM: j.c0 = `OFIS_RST_ARM_OP;
            S_RST: j.c0 = `OFIS_RST_OP;
            S_IDREAD: begin
                j.c0 = `OFIS_ID_OP;
                j.nrd = `OFIS_ID_LEN;
            end
            S_MODERD: begin
                j.c0 = `OFIS_MODE_RD_OP;
                j.addr_en = 1'b1;
                j.addr = `OFIS_MODE_ADDR;
                j.nrd = 5'h01;
            end
            S_WREN: j.c0 = `OFIS_WREN_OP;
            S_CHKLAT, S_POLL: begin
                j.c0 = `OFIS_SR_OP;
                j.nrd = `OFIS_SR_LEN;
            end
            S_MODEWR: begin
                j.c0 = `OFIS_MODE_WR_OP;
                j.addr_en = 1'b1;
                j.addr = `OFIS_MODE_ADDR;
                j.nwr = 9'h001;
                // keep other bits except parity bit, select double-rate octal
                j.wdata[7:0] = (mode & ~`OFIS_IF_MASK)
                    | {6'h00, `OFIS_IF_DTR};
                j.wdata[`OFIS_PARITY_BIT] = par;
            end
            S_RUN: begin
                j.addr_en = 1'b1;
                j.addr = addr;
                case (kind)
                    K_READ: begin
                        j.c0 = `OFIS_READ_OP0;
                        j.c1 = `OFIS_READ_OP1;
                        j.ncmd = 2'h2;
                        j.dummy = `OFIS_DUMMY_OPND;
                        j.nrd = 5'(`OFIS_READ_OPND);
                    end
                    K_ERASE: begin
                        j.c0 = `OFIS_ERASE_OP0;
                        j.c1 = `OFIS_ERASE_OP1;
                        j.ncmd = 2'h2;
                        j.addr = addr & ~(ERASE_SPAN - 32'h1);
                    end
                    default: begin
                        j.c0 = `OFIS_PROG_OP;
                        j.wdata = wd;
                        j.nwr = (len > `OFIS_PAGE_SIZE) ?
                            `OFIS_PAGE_SIZE : len;
                    end
                endcase
            end
            default: j.c0 = 8'h00;
        endcase
        return j;
    endfunction

    // sequencer state, mclk domain
    ofis_state_e st_reg, st_next;
    ofis_job_s job_reg, job_next;
    logic req_tgl_reg, req_tgl_next;
    logic launched_reg, launched_next;
    logic in_init_reg, in_init_next;
    logic [1:0] kind_reg, kind_next;
    logic [31:0] addr_reg, addr_next;
    logic [8:0] len_reg, len_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [7:0] mode_reg, mode_next;
    logic busy_reg, busy_next;
    logic init_done_reg, init_done_next;
    logic id_error_reg, id_error_next;
    logic [23:0] id_reg, id_next;
    logic [31:0] rd_reg, rd_next;
    logic op_done_reg, op_done_next;
    logic [1:0] cmode_reg, cmode_next;
    logic dn_s1, dn_s2, dn_s3;
    logic done_evt;
    // link side state
    ofis_link_e lk_st_reg, lk_st_next;
    logic [9:0] lk_t_reg, lk_t_next;
    logic lk_cs_n_reg, lk_cs_n_next;
    logic [7:0] lk_out_reg, lk_out_next;
    logic lk_oe_n_reg, lk_oe_n_next;
    logic lk_done_reg, lk_done_next;
    logic [31:0] lk_rdata_reg, lk_rdata_next;
    logic lk_rq_s1, lk_rq_s2, lk_rq_s3;
    logic [7:0] lk_in_s1, lk_in_s2;

    assign done_evt = dn_s2 ^ dn_s3;

    // step sequencing and host answers
    always_comb begin
        st_next = st_reg;
        job_next = job_reg;
        req_tgl_next = req_tgl_reg;
        launched_next = launched_reg;
        in_init_next = in_init_reg;
        kind_next = kind_reg;
        addr_next = addr_reg;
        len_next = len_reg;
        wdata_next = wdata_reg;
        mode_next = mode_reg;
        init_done_next = init_done_reg;
        id_error_next = id_error_reg;
        id_next = id_reg;
        rd_next = rd_reg;
        op_done_next = 1'b0;
        cmode_next = cmode_reg;
        case (st_reg)
            S_IDLE: begin
                if (init_start) begin
                    st_next = S_RSTARM;
                    in_init_next = 1'b1;
                    init_done_next = 1'b0;
                end else if (op_valid && init_done_reg) begin
                    kind_next = op_kind;
                    addr_next = op_addr;
                    len_next = op_len;
                    wdata_next = op_wdata;
                    in_init_next = 1'b0;
                    st_next = (op_kind == K_READ) ? S_RUN : S_WREN;
                end
            end
            S_CFGSPI: begin
                cmode_next = `OFIS_IF_SPI;
                st_next = S_IDREAD;
            end
            S_CFGDTR: begin
                cmode_next = `OFIS_IF_DTR;
                init_done_next = 1'b1;
                st_next = S_IDLE;
            end
            default: begin
                if (!launched_reg) begin
                    job_next = job_of(st_reg, kind_reg, addr_reg, len_reg,
                        wdata_reg, mode_reg, parity_en);
                    req_tgl_next = ~req_tgl_reg;
                    launched_next = 1'b1;
                end else if (done_evt) begin
                    launched_next = 1'b0;
                    case (st_reg)
                        S_RSTARM: st_next = S_RST;
                        S_RST: st_next = S_CFGSPI;
                        S_IDREAD: begin
                            id_next = lk_rdata_reg[23:0];
                            id_error_next =
                                (lk_rdata_reg[23:0] != EXPECTED_ID);
                            st_next = S_MODERD;
                        end
                        S_MODERD: begin
                            mode_next = lk_rdata_reg[7:0];
                            st_next = S_WREN;
                        end
                        S_WREN: st_next = S_CHKLAT;
                        S_CHKLAT: begin
                            if (!lk_rdata_reg[`OFIS_LATCH_BIT]) begin
                                st_next = S_WREN;
                            end else begin
                                st_next = in_init_reg ? S_MODEWR : S_RUN;
                            end
                        end
                        S_MODEWR: st_next = S_POLL;
                        S_RUN: begin
                            rd_next = lk_rdata_reg;
                            if (kind_reg == K_READ) begin
                                op_done_next = 1'b1;
                                st_next = S_IDLE;
                            end else begin
                                st_next = S_POLL;
                            end
                        end
                        S_POLL: begin
                            if (lk_rdata_reg[`OFIS_BUSY_BIT]) begin
                                st_next = S_POLL;
                            end else if (in_init_reg) begin
                                st_next = S_CFGDTR;
                            end else begin
                                op_done_next = 1'b1;
                                st_next = S_IDLE;
                            end
                        end
                        default: st_next = S_IDLE;
                    endcase
                end
            end
        endcase
        busy_next = (st_next != S_IDLE);
    end

    // sequencer registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= S_IDLE;
            job_reg <= '0;
            req_tgl_reg <= 1'b0;
            launched_reg <= 1'b0;
            in_init_reg <= 1'b0;
            kind_reg <= 2'h0;
            addr_reg <= 32'h0000_0000;
            len_reg <= 9'h000;
            wdata_reg <= 32'h0000_0000;
            mode_reg <= 8'h00;
            busy_reg <= 1'b0;
            init_done_reg <= 1'b0;
            id_error_reg <= 1'b0;
            id_reg <= 24'h00_0000;
            rd_reg <= 32'h0000_0000;
            op_done_reg <= 1'b0;
            cmode_reg <= `OFIS_IF_SPI;
            dn_s1 <= 1'b0;
            dn_s2 <= 1'b0;
            dn_s3 <= 1'b0;
        end else begin
            st_reg <= st_next;
            job_reg <= job_next;
            req_tgl_reg <= req_tgl_next;
            launched_reg <= launched_next;
            in_init_reg <= in_init_next;
            kind_reg <= kind_next;
            addr_reg <= addr_next;
            len_reg <= len_next;
            wdata_reg <= wdata_next;
            mode_reg <= mode_next;
            busy_reg <= busy_next;
            init_done_reg <= init_done_next;
            id_error_reg <= id_error_next;
            id_reg <= id_next;
            rd_reg <= rd_next;
            op_done_reg <= op_done_next;
            cmode_reg <= cmode_next;
            dn_s1 <= lk_done_reg;
            dn_s2 <= dn_s1;
            dn_s3 <= dn_s2;
        end
    end

    // phase boundaries; job is stable while a frame runs
    logic [9:0] b_cmd, b_addr, b_dum, b_wr, b_end;
    assign b_cmd = {8'h00, job_reg.ncmd};
    assign b_addr = b_cmd + (job_reg.addr_en ? {6'h00, `OFIS_ADDR_BYTES}
        : 10'h000);
    assign b_dum = b_addr + {2'h0, job_reg.dummy};
    assign b_wr = b_dum + {1'b0, job_reg.nwr};
    assign b_end = b_wr + {5'h00, job_reg.nrd} + `OFIS_SYNC_LAT;

    // link frame: cycle t_next picks the byte for the pins
    logic [9:0] rk;
    logic [1:0] ab;
    always_comb begin
        lk_st_next = lk_st_reg;
        lk_t_next = lk_t_reg;
        lk_cs_n_next = lk_cs_n_reg;
        lk_done_next = lk_done_reg;
        lk_rdata_next = lk_rdata_reg;
        lk_out_next = 8'h00;
        lk_oe_n_next = 1'b1;
        rk = lk_t_reg - b_wr - `OFIS_SYNC_LAT;
        ab = 2'h0;
        if (lk_st_reg == L_IDLE) begin
            if (lk_rq_s2 ^ lk_rq_s3) begin
                lk_st_next = L_XFER;
                lk_t_next = 10'h000;
                lk_cs_n_next = 1'b0;
                lk_rdata_next = 32'h0000_0000;
            end
        end else begin
            // capture read bytes, first byte lowest
            if (lk_t_reg >= b_wr + `OFIS_SYNC_LAT && rk < 10'h004) begin
                lk_rdata_next[rk[1:0]*8 +: 8] = lk_in_s2;
            end
            if (lk_t_reg + 10'h001 >= b_end) begin
                lk_st_next = L_IDLE;
                lk_cs_n_next = 1'b1;
                lk_done_next = ~lk_done_reg;
            end else begin
                lk_t_next = lk_t_reg + 10'h001;
            end
        end
        if (lk_st_next == L_XFER) begin
            if (lk_t_next < b_cmd) begin
                lk_out_next = (lk_t_next == 10'h000) ? job_reg.c0
                    : job_reg.c1;
                lk_oe_n_next = 1'b0;
            end else if (lk_t_next < b_addr) begin
                ab = lk_t_next[1:0] - b_cmd[1:0];
                lk_out_next = job_reg.addr[(2'h3 - ab)*8 +: 8];
                lk_oe_n_next = 1'b0;
            end else if (lk_t_next >= b_dum && lk_t_next < b_wr) begin
                ab = lk_t_next[1:0] - b_dum[1:0];
                lk_out_next = job_reg.wdata[ab*8 +: 8];
                lk_oe_n_next = 1'b0;
            end
        end
    end

    // link registers on the link clock
    always_ff @(posedge lclk or posedge rst) begin
        if (rst) begin
            lk_st_reg <= L_IDLE;
            lk_t_reg <= 10'h000;
            lk_cs_n_reg <= 1'b1;
            lk_out_reg <= 8'h00;
            lk_oe_n_reg <= 1'b1;
            lk_done_reg <= 1'b0;
            lk_rdata_reg <= 32'h0000_0000;
            lk_rq_s1 <= 1'b0;
            lk_rq_s2 <= 1'b0;
            lk_rq_s3 <= 1'b0;
            lk_in_s1 <= 8'h00;
            lk_in_s2 <= 8'h00;
        end else begin
            lk_st_reg <= lk_st_next;
            lk_t_reg <= lk_t_next;
            lk_cs_n_reg <= lk_cs_n_next;
            lk_out_reg <= lk_out_next;
            lk_oe_n_reg <= lk_oe_n_next;
            lk_done_reg <= lk_done_next;
            lk_rdata_reg <= lk_rdata_next;
            lk_rq_s1 <= req_tgl_reg;
            lk_rq_s2 <= lk_rq_s1;
            lk_rq_s3 <= lk_rq_s2;
            lk_in_s1 <= sio_in;
            lk_in_s2 <= lk_in_s1;
        end
    end

    // outputs straight from flops
    assign busy = busy_reg;
    assign init_done = init_done_reg;
    assign id_error = id_error_reg;
    assign id_value = id_reg;
    assign rd_data = rd_reg;
    assign op_done = op_done_reg;
    assign ctrl_mode = cmode_reg;
    assign volatile_mode_cfg_register = mode_reg;
    assign flash_cs_n = lk_cs_n_reg;
    assign sio_out = lk_out_reg;
    assign sio_oe_n = lk_oe_n_reg;
endmodule // ofis_seq

// >>> verification/ofis_seq_props.sv
`timescale 1ns/10ps
// watches host handshake and link framing of the sequencer
module ofis_seq_props
    import ofis_pkg::*;
#(
    parameter logic [23:0] EXPECTED_ID = 24'h5A1B2C // arbitrary value
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic lclk,
    input wire logic init_start,
    input wire logic busy,
    input wire logic init_done,
    input wire logic id_error,
    input wire logic [23:0] id_value,
    input wire logic op_done,
    input wire logic [1:0] ctrl_mode,
    input wire logic flash_cs_n,
    input wire logic [7:0] sio_out,
    input wire logic sio_oe_n
);
    // host side
    a_init_busy: assert property (@(posedge mclk) disable iff (rst)
        (!busy && init_start) |=> busy)
        else $error("busy not raised after init start");
    a_done_pulse: assert property (@(posedge mclk) disable iff (rst)
        op_done |=> !op_done)
        else $error("op done longer than one cycle");
    a_id_compare: assert property (@(posedge mclk) disable iff (rst)
        init_done |-> (id_error == (id_value != EXPECTED_ID)))
        else $error("identity flag disagrees with value");
    a_mode_legal: assert property (@(posedge mclk) disable iff (rst)
        (ctrl_mode == 2'h0 || ctrl_mode == 2'h2)
        && (!init_done || ctrl_mode == 2'h2))
        else $error("illegal controller mode");
    // link side
    a_read_opcode: assert property (@(posedge lclk) disable iff (rst)
        ($fell(flash_cs_n) && sio_out == 8'hEE) |=> sio_out == 8'h13)
        else $error("read second opcode wrong");
    a_read_addr: assert property (@(posedge lclk) disable iff (rst)
        ($fell(flash_cs_n) && sio_out == 8'hEE)
        |-> ##2 (!sio_oe_n)[*4] ##1 sio_oe_n)
        else $error("read address phase not four bytes");
    a_read_frame: assert property (@(posedge lclk) disable iff (rst)
        ($fell(flash_cs_n) && sio_out == 8'hEE)
        |-> ##43 !flash_cs_n ##1 flash_cs_n)
        else $error("read frame length wrong");
    a_id_frame: assert property (@(posedge lclk) disable iff (rst)
        ($fell(flash_cs_n) && sio_out == 8'h9F)
        |-> ##5 !flash_cs_n ##1 flash_cs_n)
        else $error("identity frame length wrong");
    a_erase_open: assert property (@(posedge lclk) disable iff (rst)
        ($fell(flash_cs_n) && sio_out == 8'h21)
        |=> sio_out == 8'hDE ##1 (!sio_oe_n)[*4])
        else $error("erase opcode or address wrong");
    a_status_len: assert property (@(posedge lclk) disable iff (rst)
        ($fell(flash_cs_n) && sio_out == 8'h05)
        |-> ##3 !flash_cs_n ##1 flash_cs_n)
        else $error("status frame not one byte");
endmodule // ofis_seq_props

bind ofis_seq ofis_seq_props #(.EXPECTED_ID(EXPECTED_ID)) u_props (
    .mclk(mclk), .rst(rst), .lclk(lclk), .init_start(init_start),
    .busy(busy), .init_done(init_done), .id_error(id_error),
    .id_value(id_value), .op_done(op_done), .ctrl_mode(ctrl_mode),
    .flash_cs_n(flash_cs_n), .sio_out(sio_out), .sio_oe_n(sio_oe_n)
);

// >>> verification/ofis_flash_model.sv
`timescale 1ns/10ps
// behavioural flash on the octal link, one byte per link clock
module ofis_flash_model (
    input wire logic lclk,
    input wire logic flash_cs_n,
    input wire logic [7:0] sio_out,
    input wire logic sio_oe_n,
    input wire logic [23:0] ident,
    output logic [7:0] sio_in
);
    logic [7:0] mode_reg = 8'hF1;
    logic [7:0] op = 8'h00;
    logic [7:0] last_op = 8'h00;
    logic [7:0] mode_wr = 8'h00;
    logic [7:0] cur;
    logic [7:0] nb;
    logic [31:0] addr = 32'h0;
    logic [31:0] erase_addr = 32'h0;
    logic [31:0] rd_addr = 32'h0;
    logic [31:0] prog_w = 32'h0;
    logic [9:0] t = 10'h000;
    logic [9:0] prog_n = 10'h000;
    logic [9:0] rs;
    logic [9:0] rn;
    logic [9:0] k;
    logic [1:0] busy_left = 2'h0;
    logic latch = 1'b0;
    logic armed = 1'b0;
    logic drive;
    int erases = 0;
    initial sio_in = 8'h5A;
    // next read byte and where the read phase sits in the frame
    always_comb begin
        cur = (t == 10'h000) ? sio_out : op;
        rs = (cur == 8'hEE) ? 10'h01A : (cur == 8'h71) ? 10'h005 : 10'h001;
        rn = (cur == 8'hEE) ? 10'h010 : (cur == 8'h9F) ? 10'h003 : 10'h001;
        k = t + 10'h001 - rs;
        drive = (cur inside {8'hEE, 8'h9F, 8'h71, 8'h05}) && !flash_cs_n
            && (t + 10'h001 >= rs) && (t + 10'h001 < rs + rn);
        case (cur)
            8'hEE: nb = addr[7:0] + k[7:0];
            8'h9F: nb = 8'(ident >> (8 * k));
            8'h71: nb = mode_reg;
            default: nb = {6'h00, latch, busy_left != 2'h0};
        endcase
    end
    // frame capture, commands act when select is released
    always @(posedge lclk) begin
        sio_in <= drive ? nb : ~sio_in;
        if (flash_cs_n) begin
            if (t != 10'h000) begin
                last_op <= op;
                armed <= (op == 8'h66);
                case (op)
                    8'h06: latch <= 1'b1;
                    8'h99: if (armed) begin
                        mode_reg <= 8'h00;
                        latch <= 1'b0;
                    end
                    8'h21: if (latch) begin
                        erase_addr <= addr;
                        erases <= erases + 1;
                        latch <= 1'b0;
                        busy_left <= 2'h3;
                    end
                    8'h12: if (latch) begin
                        prog_n <= t - 10'h007;
                        latch <= 1'b0;
                        busy_left <= 2'h3;
                    end
                    8'h72: if (latch) begin
                        mode_reg <= mode_wr;
                        latch <= 1'b0;
                        busy_left <= 2'h2;
                    end
                    8'h05: if (busy_left != 2'h0) busy_left <= busy_left - 2'h1;
                    8'hEE: rd_addr <= addr;
                    default: ;
                endcase
            end
            t <= 10'h000;
        end else begin
            if (t == 10'h000) op <= sio_out;
            if (t >= ((op == 8'hEE || op == 8'h21) ? 10'h002 : 10'h001)
                && t <= ((op == 8'hEE || op == 8'h21) ? 10'h005 : 10'h004))
                addr <= {addr[23:0], sio_out};
            if (op == 8'h72 && t == 10'h005) mode_wr <= sio_out;
            // first four program data bytes, first byte lowest
            if (op == 8'h12 && t >= 10'h005 && t <= 10'h008)
                prog_w <= {sio_out, prog_w[31:8]};
            t <= t + 10'h001;
        end
    end
endmodule // ofis_flash_model

// >>> verification/tb.sv
`timescale 1ns/10ps
module tb;
    import ofis_pkg::*;
    localparam logic [23:0] ID_OK = 24'h5A1B2C; // arbitrary value
    logic mclk = 0;
    logic lclk = 0;
    logic rst = 1;
    logic init_start = 0;
    logic op_valid = 0;
    logic parity_en = 0;
    logic [1:0] op_kind = 0;
    logic [31:0] op_addr = 0;
    logic [31:0] op_wdata = 32'hA1B2C3D4;
    logic [8:0] op_len = 0;
    logic [23:0] ident = ID_OK;
    logic busy, init_done, id_error, op_done, flash_cs_n, sio_oe_n;
    logic [23:0] id_value;
    logic [31:0] rd_data;
    logic [1:0] ctrl_mode;
    logic [7:0] vmode, sio_out, sio_in;
    logic [8:0] plen [3] = '{9'h005, 9'h100, 9'h12C};
    int miscompares = 0;
    int total_checks = 0;
    // clocks, phases unrelated
    initial forever #4 mclk = ~mclk;
    initial begin
        #1.3;
        forever #6 lclk = ~lclk;
    end
    ofis_seq #(.EXPECTED_ID(ID_OK)) uut (
        .mclk(mclk), .rst(rst), .lclk(lclk), .init_start(init_start),
        .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr),
        .op_len(op_len), .op_wdata(op_wdata), .parity_en(parity_en),
        .busy(busy), .init_done(init_done), .id_error(id_error),
        .id_value(id_value), .rd_data(rd_data), .op_done(op_done),
        .ctrl_mode(ctrl_mode), .volatile_mode_cfg_register(vmode),
        .flash_cs_n(flash_cs_n), .sio_out(sio_out), .sio_oe_n(sio_oe_n),
        .sio_in(sio_in)
    );
    ofis_flash_model fm (
        .lclk(lclk), .flash_cs_n(flash_cs_n), .sio_out(sio_out),
        .sio_oe_n(sio_oe_n), .ident(ident), .sio_in(sio_in)
    );
    task automatic close_out;
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait: 0 op done, 1 init end, 2 identity frame seen
    task automatic wait_end(input int what);
        int n;
        for (n = 0; n < 40000; n++) begin
            @(negedge mclk);
            if (what == 0 && op_done === 1'b1) break;
            if (what == 1 && init_done === 1'b1 && busy === 1'b0) break;
            if (what == 2 && fm.last_op === 8'h9F) break;
        end
        if (n == 40000) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic start_op(input logic [1:0] kd, input logic [31:0] a,
                            input logic [8:0] n);
        @(negedge mclk);
        op_kind = kd;
        op_addr = a;
        op_len = n;
        op_valid = 1;
        @(negedge mclk);
        op_valid = 0;
    endtask
    task automatic start_init(input logic par);
        @(negedge mclk);
        parity_en = par;
        init_start = 1;
        @(negedge mclk);
        init_start = 0;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rst = 0;
        // op before init is ignored
        start_op(K_READ, 32'h0, 9'h000);
        repeat (4) @(negedge mclk);
        check("busy before init", 32'h0, {31'h0, busy});
        // first init, parity on, matching identity
        start_init(1'b1);
        wait_end(1);
        check("id error", 32'h0, {31'h0, id_error});
        check("id value", {8'h00, ID_OK}, {8'h00, id_value});
        check("mode read back", 32'h0, {24'h0, vmode});
        check("flash mode", 32'h0A, {24'h0, fm.mode_reg});
        check("ctrl mode", 32'h2, {30'h0, ctrl_mode});
        // read, with an erase request refused while busy
        start_op(K_READ, 32'h1000_0040, 9'h000);
        start_op(K_ERASE, 32'h0000_5000, 9'h000);
        wait_end(0);
        check("read data", 32'h43424140, rd_data);
        check("read addr", 32'h1000_0040, fm.rd_addr);
        check("refused erase", 32'h0, fm.erases);
        // erase aligns to the sector and waits for busy clear
        start_op(K_ERASE, 32'h0000_3456, 9'h000);
        wait_end(0);
        check("erase count", 32'h1, fm.erases);
        check("erase addr", 32'h0000_3456 & ~((32'h1 << 12) - 1),
              fm.erase_addr);
        check("busy left", 32'h0, {30'h0, fm.busy_left});
        // program lengths around the page size
        for (int i = 0; i < 3; i++) begin
            start_op(K_PROG, 32'h0000_2000, plen[i]);
            wait_end(0);
            check("program bytes", (plen[i] > 9'h100) ? 32'd256 : 32'(plen[i]),
                  {22'h0, fm.prog_n});
            check("prog busy left", 32'h0, {30'h0, fm.busy_left});
            check("program data", op_wdata, fm.prog_w);
        end
        // second init from double-rate mode, parity off, wrong identity
        @(negedge mclk);
        ident = 24'h123456;
        start_init(1'b0);
        wait_end(2);
        check("ctrl after reset", 32'h0, {30'h0, ctrl_mode});
        wait_end(1);
        check("id mismatch", 32'h1, {31'h0, id_error});
        check("id value 2", 32'h123456, {8'h00, id_value});
        check("flash mode 2", 32'h02, {24'h0, fm.mode_reg});
        check("ctrl mode 2", 32'h2, {30'h0, ctrl_mode});
        close_out();
    end
endmodule // tb
